// >>> common/cdc_defines.vh
// register map, field positions, reset values and timing constants of the cable diagnostic block
`ifndef CDC_DEFINES_VH
`define CDC_DEFINES_VH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define CDC_IDX_CTRL      6'h16
`define CDC_IDX_WIN       6'h17
`define CDC_IDX_PEAK      6'h18
`define CDC_IDX_THR       6'h19
`define CDC_IDX_VCTRL     6'h1A
`define CDC_IDX_VSUM      6'h1B

// ************************************************************
// reset values and writable masks
// ************************************************************
`define CDC_CTRL_RST      16'h0020
`define CDC_CTRL_RW_MASK  16'hF7BF
`define CDC_WIN_RST       16'h00FF
`define CDC_VCTRL_RW_MASK 16'h000F
`define CDC_ZERO16        16'h0000

// ************************************************************
// field positions
// ************************************************************
`define CDC_LAUNCH_BIT    11
`define CDC_NEG_BIT       7
`define CDC_THR_MSB       5
`define CDC_THR_LSB       0
`define CDC_OPEN_MSB      15
`define CDC_OPEN_LSB      8
`define CDC_CLOSE_MSB     7
`define CDC_CLOSE_LSB     0
`define CDC_VRDY_BIT      15
`define CDC_VFRZ_BIT      3
`define CDC_VTMR_MSB      2
`define CDC_VTMR_LSB      1
`define CDC_VEN_BIT       0

// ************************************************************
// capture and variance timing
// ************************************************************
`define CDC_TIME_LAST     8'hFF
`define CDC_UNIT_CYCLES   32'h0002_0000
`define CDC_UNITS_PER_SEL 3'h2

// ************************************************************
// bus answers
// ************************************************************
`define CDC_RESP_OKAY     2'h0
`define CDC_RESP_SLVERR   2'h2

`endif

// >>> core/cdc_cable_diag.v
// cable diagnostic capture: reflectometry window capture, variance sum readout, AXI4-Lite registers
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`include "cdc_defines.vh"

module cdc_cable_diag #(
  parameter [31:0] UNIT_CYCLES = `CDC_UNIT_CYCLES
) (
  input  wire        MCLK,
  input  wire        RST_B,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire [5:0]  REFLECT_SAMPLE,
  input  wire        NOISE_VALID,
  input  wire [15:0] NOISE_SQ,
  output reg         PULSE_LAUNCH,
  output reg         CAPTURE_BUSY
);

  // ************************************************************
  // state encodings
  // ************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  // ************************************************************
  // declarations
  // ************************************************************
  reg  [7:0]  aw_addr_reg;
  reg         aw_held_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_held_reg;

  reg  [15:0] reflect_control_reg;
  reg  [15:0] reflect_window_reg;
  reg  [15:0] reflect_peak_value_reg;
  reg  [15:0] reflect_threshold_result_reg;
  reg  [15:0] noise_variance_control_reg;
  reg  [31:0] var_data_reg;
  reg         var_high_next_reg;

  reg  [1:0]  state_reg;
  reg  [7:0]  time_reg;
  reg         seen_reg;
  reg  [5:0]  peak_reg;
  reg  [7:0]  peak_first_time_reg;
  reg         threshold_hit_flag_reg;
  reg  [7:0]  threshold_hit_time_reg;

  reg  [15:0] rd_word;
  reg         rd_hit;
  reg  [15:0] wr_mask;

  wire        do_write;
  wire [5:0]  wr_idx;
  wire [5:0]  rd_idx;
  wire        do_read;
  wire        wr_ctrl;
  wire        wr_win;
  wire        wr_vctrl;
  wire [15:0] wr_val;
  wire        sum_read;
  wire        second_read;
  wire        timer_written;
  wire        var_done;
  wire [31:0] var_sum;
  wire        negative_peak_sel;
  wire [5:0]  rx_threshold;
  wire [7:0]  window_open_time;
  wire [7:0]  window_close_time;
  wire        in_window;
  wire        better;
  wire        hit;
  wire        finish;
  wire        launch_req;

  // ************************************************************
  // bus slave: write path
  // ************************************************************
  assign do_write = aw_held_reg && w_held_reg && !S_AXI_BVALID;
  assign wr_idx   = aw_addr_reg[7:2];
  assign wr_ctrl  = do_write && (wr_idx == `CDC_IDX_CTRL);
  assign wr_win   = do_write && (wr_idx == `CDC_IDX_WIN);
  assign wr_vctrl = do_write && (wr_idx == `CDC_IDX_VCTRL);

  always @* begin
    wr_mask = {{8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  end

  assign wr_val = w_data_reg[15:0] & wr_mask;

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      aw_addr_reg   <= 8'h00;
      aw_held_reg   <= 1'b0;
      w_data_reg    <= 32'h0000_0000;
      w_strb_reg    <= 4'h0;
      w_held_reg    <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `CDC_RESP_OKAY;
    end else begin
      S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY) && !S_AXI_BVALID;
      S_AXI_WREADY  <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY) && !S_AXI_BVALID;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_addr_reg <= S_AXI_AWADDR;
        aw_held_reg <= 1'b1;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_data_reg <= S_AXI_WDATA;
        w_strb_reg <= S_AXI_WSTRB;
        w_held_reg <= 1'b1;
      end
      if (do_write) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= (wr_idx >= `CDC_IDX_CTRL && wr_idx <= `CDC_IDX_VSUM) ?
                        `CDC_RESP_OKAY : `CDC_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // ************************************************************
  // bus slave: read path
  // ************************************************************
  assign do_read     = S_AXI_ARVALID && S_AXI_ARREADY;
  assign rd_idx      = S_AXI_ARADDR[7:2];
  assign sum_read    = do_read && (rd_idx == `CDC_IDX_VSUM);
  assign second_read = sum_read && var_high_next_reg;

  always @* begin
    rd_word = `CDC_ZERO16;
    rd_hit  = 1'b1;
    case (rd_idx)
      `CDC_IDX_CTRL:  rd_word = reflect_control_reg;
      `CDC_IDX_WIN:   rd_word = reflect_window_reg;
      `CDC_IDX_PEAK:  rd_word = reflect_peak_value_reg;
      `CDC_IDX_THR:   rd_word = reflect_threshold_result_reg;
      `CDC_IDX_VCTRL: rd_word = noise_variance_control_reg;
      // low half first, then high half
      `CDC_IDX_VSUM:  rd_word = var_high_next_reg ? var_data_reg[31:16] : var_data_reg[15:0];
      default:        rd_hit  = 1'b0;
    endcase
  end

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= `CDC_RESP_OKAY;
    end else begin
      S_AXI_ARREADY <= !S_AXI_RVALID && !do_read;
      if (do_read) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= {16'h0000, rd_word};
        S_AXI_RRESP  <= rd_hit ? `CDC_RESP_OKAY : `CDC_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

  // ************************************************************
  // reflectometry control and window registers
  // ************************************************************
  assign negative_peak_sel = reflect_control_reg[`CDC_NEG_BIT];
  assign rx_threshold      = reflect_control_reg[`CDC_THR_MSB:`CDC_THR_LSB];
  assign window_open_time  = reflect_window_reg[`CDC_OPEN_MSB:`CDC_OPEN_LSB];
  assign window_close_time = reflect_window_reg[`CDC_CLOSE_MSB:`CDC_CLOSE_LSB];
  assign launch_req        = wr_ctrl && wr_val[`CDC_LAUNCH_BIT] && (state_reg == ST_IDLE);

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      reflect_control_reg <= `CDC_CTRL_RST;
      reflect_window_reg  <= `CDC_WIN_RST;
    end else begin
      if (wr_ctrl) begin
        reflect_control_reg <= (reflect_control_reg & ~(wr_mask & `CDC_CTRL_RW_MASK)) |
                               (wr_val & `CDC_CTRL_RW_MASK);
      end
      if (launch_req) begin
        reflect_control_reg[`CDC_LAUNCH_BIT] <= 1'b1;
      end else if (finish) begin
        reflect_control_reg[`CDC_LAUNCH_BIT] <= 1'b0;
      end
      if (wr_win) begin
        reflect_window_reg <= (reflect_window_reg & ~wr_mask) | wr_val;
      end
    end
  end

  // ************************************************************
  // reflectometry capture
  // ************************************************************
  // window bounds inclusive, time counted from launch
  assign in_window = (time_reg >= window_open_time) && (time_reg <= window_close_time);
  // strict compare keeps the first occurrence of the peak
  assign better    = !seen_reg || (negative_peak_sel ? (REFLECT_SAMPLE < peak_reg) : (REFLECT_SAMPLE > peak_reg));
  assign hit       = negative_peak_sel ? (REFLECT_SAMPLE < rx_threshold) : (REFLECT_SAMPLE > rx_threshold);
  assign finish    = (state_reg == ST_RUN) &&
                     (time_reg == window_close_time || time_reg == `CDC_TIME_LAST);

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg                    <= ST_IDLE;
      time_reg                     <= 8'h00;
      seen_reg                     <= 1'b0;
      peak_reg                     <= 6'h00;
      peak_first_time_reg          <= 8'h00;
      threshold_hit_flag_reg       <= 1'b0;
      threshold_hit_time_reg       <= 8'h00;
      reflect_peak_value_reg       <= `CDC_ZERO16;
      reflect_threshold_result_reg <= `CDC_ZERO16;
      PULSE_LAUNCH                 <= 1'b0;
      CAPTURE_BUSY                 <= 1'b0;
    end else begin
      PULSE_LAUNCH <= launch_req;
      case (state_reg)
        ST_IDLE: begin
          CAPTURE_BUSY <= launch_req;
          if (launch_req) begin
            state_reg              <= ST_RUN;
            time_reg               <= 8'h00;
            seen_reg               <= 1'b0;
            threshold_hit_flag_reg <= 1'b0;
          end
        end
        ST_RUN: begin
          time_reg <= time_reg + 8'h01;
          if (in_window) begin
            seen_reg <= 1'b1;
            if (better) begin
              peak_reg            <= REFLECT_SAMPLE;
              peak_first_time_reg <= time_reg;
            end
            if (hit && !threshold_hit_flag_reg) begin
              threshold_hit_flag_reg <= 1'b1;
              threshold_hit_time_reg <= time_reg;
            end
          end
          if (finish) begin
            state_reg    <= ST_IDLE;
            CAPTURE_BUSY <= 1'b0;
            // results change only here, as the launch bit clears
            reflect_peak_value_reg <= (in_window && better) ?
                                      {2'b00, REFLECT_SAMPLE, time_reg} :
                                      (seen_reg ? {2'b00, peak_reg, peak_first_time_reg} : `CDC_ZERO16);
            if (in_window && hit && !threshold_hit_flag_reg) begin
              reflect_threshold_result_reg <= {7'h00, 1'b1, time_reg};
            end else begin
              reflect_threshold_result_reg <= {7'h00, threshold_hit_flag_reg,
                                               threshold_hit_flag_reg ? threshold_hit_time_reg : 8'h00};
            end
          end
        end
        default: begin
          state_reg    <= ST_IDLE;
          CAPTURE_BUSY <= 1'b0;
        end
      endcase
    end
  end

  // ************************************************************
  // variance control, readout and ready/freeze handling
  // ************************************************************
  assign timer_written = wr_vctrl && (wr_mask[`CDC_VTMR_MSB:`CDC_VTMR_LSB] != 2'b00);

  cdc_var_accum #(
    .UNIT_CYCLES (UNIT_CYCLES)
  ) u_var_accum (
    .clk          (MCLK),
    .rst_b        (RST_B),
    .enable       (noise_variance_control_reg[`CDC_VEN_BIT]),
    .period_sel   (noise_variance_control_reg[`CDC_VTMR_MSB:`CDC_VTMR_LSB]),
    .restart      (timer_written),
    .sample_valid (NOISE_VALID),
    .sample       (NOISE_SQ),
    .done_reg     (var_done),
    .sum_reg      (var_sum)
  );

  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      noise_variance_control_reg <= `CDC_ZERO16;
      var_data_reg               <= 32'h0000_0000;
      var_high_next_reg          <= 1'b0;
    end else begin
      // freeze blocks loading a new sum
      if (var_done && !noise_variance_control_reg[`CDC_VFRZ_BIT]) begin
        var_data_reg <= var_sum;
      end
      // reserved bits kept zero by the mask
      if (wr_vctrl) begin
        noise_variance_control_reg[`CDC_VFRZ_BIT:`CDC_VEN_BIT] <=
          (noise_variance_control_reg[`CDC_VFRZ_BIT:`CDC_VEN_BIT] & ~wr_mask[`CDC_VFRZ_BIT:`CDC_VEN_BIT]) |
          wr_val[`CDC_VFRZ_BIT:`CDC_VEN_BIT];
      end else if (second_read) begin
        noise_variance_control_reg[`CDC_VFRZ_BIT] <= 1'b0;
      end
      // a new load wins over the clearing read
      if (var_done && !noise_variance_control_reg[`CDC_VFRZ_BIT]) begin
        noise_variance_control_reg[`CDC_VRDY_BIT] <= 1'b1;
      end else if (second_read) begin
        noise_variance_control_reg[`CDC_VRDY_BIT] <= 1'b0;
      end
      // half pointer restarts on freeze set or any other read
      if (wr_vctrl && wr_val[`CDC_VFRZ_BIT]) begin
        var_high_next_reg <= 1'b0;
      end else if (sum_read) begin
        var_high_next_reg <= !var_high_next_reg;
      end else if (do_read) begin
        var_high_next_reg <= 1'b0;
      end
    end
  end

endmodule

// >>> core/cdc_var_accum.v
// variance sum accumulator with selectable period timer
`timescale 1ns/1ns
`include "cdc_defines.vh"

module cdc_var_accum #(
  parameter [31:0] UNIT_CYCLES = `CDC_UNIT_CYCLES
) (
  input  wire        clk,
  input  wire        rst_b,
  input  wire        enable,
  input  wire [1:0]  period_sel,
  input  wire        restart,
  input  wire        sample_valid,
  input  wire [15:0] sample,
  output reg         done_reg,
  output reg  [31:0] sum_reg
);

  reg  [31:0] cyc_reg;
  reg  [2:0]  unit_reg;
  reg  [31:0] acc_reg;
  wire [3:0]  units_needed;
  wire        unit_end;
  wire        period_end;
  wire [31:0] acc_in;

  // period is (sel+1) times two units of UNIT_CYCLES clocks
  assign units_needed = ({2'b00, period_sel} + 4'h1) * {1'b0, `CDC_UNITS_PER_SEL};
  assign unit_end     = (cyc_reg == UNIT_CYCLES - 32'h1);
  assign period_end   = unit_end && ({1'b0, unit_reg} == units_needed - 4'h1);
  assign acc_in       = acc_reg + (sample_valid ? {16'h0000, sample} : 32'h0000_0000);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cyc_reg  <= 32'h0000_0000;
      unit_reg <= 3'h0;
      acc_reg  <= 32'h0000_0000;
      done_reg <= 1'b0;
      sum_reg  <= 32'h0000_0000;
    end else if (!enable || restart) begin
      // idle while disabled, start over whenever the period field is written
      cyc_reg  <= 32'h0000_0000;
      unit_reg <= 3'h0;
      acc_reg  <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else begin
      done_reg <= period_end;
      if (unit_end) begin
        cyc_reg  <= 32'h0000_0000;
        unit_reg <= period_end ? 3'h0 : unit_reg + 3'h1;
      end else begin
        cyc_reg  <= cyc_reg + 32'h1;
      end
      if (period_end) begin
        sum_reg <= acc_in;
        acc_reg <= 32'h0000_0000;
      end else begin
        acc_reg <= acc_in;
      end
    end
  end

endmodule

// >>> verif/cdc_cable_diag_props.sv
// port-level assertions for the cable diagnostic block
`timescale 1ns/1ns
module cdc_cable_diag_chk #(
  parameter [31:0] UNIT_CYCLES = 32'h10
) (
  input wire        MCLK,
  input wire        RST_B,
  input wire        S_AXI_AWVALID,
  input wire        S_AXI_AWREADY,
  input wire        S_AXI_WVALID,
  input wire        S_AXI_WREADY,
  input wire        S_AXI_BVALID,
  input wire        S_AXI_ARVALID,
  input wire        S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire [1:0]  S_AXI_RRESP,
  input wire        S_AXI_RVALID,
  input wire        S_AXI_RREADY,
  input wire        PULSE_LAUNCH,
  input wire        CAPTURE_BUSY
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);
  // ************************************************************
  // sequences
  // ************************************************************
  sequence s_launch;
    PULSE_LAUNCH && CAPTURE_BUSY ##1 CAPTURE_BUSY;
  endsequence
  sequence s_wr_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  // ************************************************************
  // properties
  // ************************************************************
  a_launch_single: assert property (PULSE_LAUNCH |=> !PULSE_LAUNCH)
    else $error("launch pulse too long");
  a_launch_busy: assert property (PULSE_LAUNCH |-> CAPTURE_BUSY)
    else $error("launch without busy");
  a_busy_bounded: assert property (s_launch |-> ##[1:256] !CAPTURE_BUSY)
    else $error("capture overran window");
  a_no_relaunch: assert property (CAPTURE_BUSY && $past(CAPTURE_BUSY) |-> !PULSE_LAUNCH)
    else $error("launch during capture");
  a_rdata_upper: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0000)
    else $error("upper read bits set");
  a_slverr_zero: assert property (S_AXI_RVALID && S_AXI_RRESP == 2'h2 |-> S_AXI_RDATA == 32'h0)
    else $error("error read with data");
  a_read_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read not answered");
  a_write_resp: assert property (s_wr_taken |-> ##[1:3] S_AXI_BVALID)
    else $error("write not answered");
  a_resp_blocks: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
    else $error("address taken with response pending");
endmodule

bind cdc_cable_diag cdc_cable_diag_chk #(.UNIT_CYCLES(UNIT_CYCLES)) i_chk (
  .MCLK(MCLK), .RST_B(RST_B), .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY),
  .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .PULSE_LAUNCH(PULSE_LAUNCH), .CAPTURE_BUSY(CAPTURE_BUSY));

// >>> verif/cdc_front_model.sv
// front-end model: reflection samples by capture time, noise power stream
`timescale 1ns/1ns
module cdc_front_model (
  input  wire        MCLK,
  input  wire        RST_B,
  input  wire        PULSE_LAUNCH,
  input  wire        CAPTURE_BUSY,
  input  wire [15:0] noise_val,
  output reg  [5:0]  REFLECT_SAMPLE,
  output reg         NOISE_VALID,
  output reg  [15:0] NOISE_SQ
);
  reg  [5:0] smp [0:255];
  reg  [7:0] t_reg;
  wire [7:0] t_nx = t_reg + 8'h01;
  // sample for time t stands on the pins in the cycle the block counts t
  always @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      t_reg <= 8'h00;
      REFLECT_SAMPLE <= 6'h20;
      NOISE_VALID <= 1'b0;
      NOISE_SQ <= 16'h0000;
    end else begin
      NOISE_VALID <= 1'b1;
      NOISE_SQ <= noise_val;
      if (PULSE_LAUNCH) begin
        t_reg <= 8'h01;
        REFLECT_SAMPLE <= smp[1];
      end else if (CAPTURE_BUSY) begin
        t_reg <= t_nx;
        REFLECT_SAMPLE <= smp[t_nx];
      end else begin
        REFLECT_SAMPLE <= smp[0];
      end
    end
  end
endmodule

// >>> verif/tb_top.sv
// self-checking bench for the cable diagnostic block
`timescale 1ns/1ns
`include "cdc_defines.vh"
module tb_top;
  localparam [31:0] UNIT = 32'h10;
  reg         MCLK, RST_B, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr, o, c;
  reg  [31:0] wdata, rv, d, e, lo, hi;
  reg  [3:0]  wstrb;
  reg  [15:0] noise_val, k;
  reg  [5:0]  th;
  reg  [1:0]  sel, r, last_rresp;
  reg         ng;
  wire        awready, wready, bvalid, arready, rvalid, nvalid, pulse, busy;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [5:0]  smp_w;
  wire [15:0] nsq;
  integer     seed = 32'h92A6;
  int         err_count, check_count, i, t, n;

  cdc_cable_diag #(.UNIT_CYCLES(UNIT)) i_dut (
    .MCLK(MCLK), .RST_B(RST_B), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .REFLECT_SAMPLE(smp_w), .NOISE_VALID(nvalid),
    .NOISE_SQ(nsq), .PULSE_LAUNCH(pulse), .CAPTURE_BUSY(busy));
  cdc_front_model i_fe (
    .MCLK(MCLK), .RST_B(RST_B), .PULSE_LAUNCH(pulse), .CAPTURE_BUSY(busy), .noise_val(noise_val),
    .REFLECT_SAMPLE(smp_w), .NOISE_VALID(nvalid), .NOISE_SQ(nsq));

  initial begin
    MCLK = 1'b0;
    forever #50 MCLK = ~MCLK;
  end
  // ************************************************************
  // bus tasks and checks
  // ************************************************************
  task automatic wr(input [5:0] idx, input [15:0] dv, output [1:0] resp);
    awaddr <= {idx, 2'b00};
    wdata <= {16'h0000, dv};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge MCLK);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    bready <= 1'b1;
    do @(posedge MCLK); while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input [5:0] idx, output [31:0] dv);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge MCLK); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge MCLK); while (!rvalid);
    dv = rdata;
    last_rresp = rresp;
    rready <= 1'b0;
  endtask
  task automatic chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input [5:0] idx, input [31:0] exp);
    rd(idx, d);
    chk(d, exp);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ************************************************************
  // expectations
  // ************************************************************
  function automatic [31:0] exp_cap(input [7:0] op, input [7:0] cl, input neg, input [5:0] thr);
    reg [5:0] pk;
    reg [7:0] pt, ht;
    reg hit, any;
    int u;
    {pk, pt, ht, hit, any} = 0;
    for (u = op; u <= cl; u++) begin
      if (!any || (neg ? i_fe.smp[u] < pk : i_fe.smp[u] > pk)) begin
        pk = i_fe.smp[u];
        pt = u[7:0];
      end
      any = 1'b1;
      if (!hit && (neg ? i_fe.smp[u] < thr : i_fe.smp[u] > thr)) begin
        hit = 1'b1;
        ht = u[7:0];
      end
    end
    exp_cap = {7'h00, hit, ht, 2'b00, pk, pt};
  endfunction
  function automatic [31:0] per(input [1:0] s);
    per = ({30'h0, s} + 32'h1) * 32'h2 * UNIT;
  endfunction
  // ************************************************************
  // tests
  // ************************************************************
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = 0;
    wstrb = 4'hF;
    noise_val = 16'h0000;
    RST_B = 1'b0;
    repeat (6) @(posedge MCLK);
    RST_B <= 1'b1;
    repeat (200) @(posedge MCLK);
    rchk(`CDC_IDX_CTRL, `CDC_CTRL_RST);
    rchk(`CDC_IDX_WIN, `CDC_WIN_RST);
    rchk(`CDC_IDX_PEAK, 32'h0);
    rchk(`CDC_IDX_THR, 32'h0);
    rchk(`CDC_IDX_VCTRL, 32'h0);
    rchk(`CDC_IDX_VSUM, 32'h0);
    for (i = 0; i < 3; i++) begin
      wr(i == 2 ? `CDC_IDX_VSUM : `CDC_IDX_PEAK + i[5:0], 16'hFFFF, r);
      rchk(i == 2 ? `CDC_IDX_VSUM : `CDC_IDX_PEAK + i[5:0], 32'h0);
      chk(r, `CDC_RESP_OKAY);
    end
    wr(`CDC_IDX_VCTRL, 16'hFFFF, r);
    rchk(`CDC_IDX_VCTRL, 32'h000F);
    chk(last_rresp, `CDC_RESP_OKAY);
    wr(`CDC_IDX_VCTRL, 16'h0000, r);
    wr(6'h3F, 16'h1234, r);
    chk(r, `CDC_RESP_SLVERR);
    rchk(6'h3F, 32'h0);
    chk(last_rresp, `CDC_RESP_SLVERR);
    wstrb <= 4'h2;
    wr(`CDC_IDX_WIN, 16'h1234, r);
    wstrb <= 4'hF;
    rchk(`CDC_IDX_WIN, 32'h12FF);
    $display("register test done");
    for (i = 0; i < 8; i++) begin
      rv = $random(seed);
      o = {3'h0, rv[4:0]};
      c = o + {3'h0, rv[9:5]};
      ng = i[0];
      th = (i == 2) ? 6'h3F : rv[15:10];
      if (i == 0) {o, c} = 16'h00FF;
      if (i == 1) {o, c} = {o | 8'h01, o}; // close before open for even o, equal to open for odd o, against the software advice
      for (t = 0; t < 256; t++) begin
        rv = $random(seed);
        i_fe.smp[t] = rv[5:0];
      end
      wr(`CDC_IDX_WIN, {o, c}, r);
      rchk(`CDC_IDX_WIN, {16'h0000, o, c});
      wr(`CDC_IDX_CTRL, {4'h0, 1'b1, 3'h0, ng, 1'b0, th}, r);
      n = 0;
      do begin
        rd(`CDC_IDX_CTRL, d);
        n++;
      end while (d[11] === 1'b1 && n < 200);
      chk(d, {24'h0, ng, 1'b0, th});
      e = exp_cap(o, c, ng, th);
      rchk(`CDC_IDX_PEAK, {16'h0, e[15:0]});
      rchk(`CDC_IDX_THR, {16'h0, e[31:16]});
      $display("capture test %0d done", i);
    end
    for (i = 0; i < 4; i++) begin
      rv = $random(seed);
      k = rv[15:0];
      sel = i[1:0];
      noise_val <= k;
      repeat (3) @(posedge MCLK);
      wr(`CDC_IDX_VCTRL, {13'h0, sel, 1'b1}, r);
      n = 0;
      do begin
        rd(`CDC_IDX_VCTRL, d);
        n++;
      end while (d[15] !== 1'b1 && n < 200);
      chk(n < 200, 1'b1);
      wr(`CDC_IDX_VCTRL, {12'h0, 1'b1, sel, 1'b1}, r);
      rv = $random(seed);
      noise_val <= rv[15:0];
      repeat (2 * per(sel) + 20) @(posedge MCLK);
      wr(`CDC_IDX_VCTRL, {12'h0, 1'b1, sel, 1'b0}, r);
      rd(`CDC_IDX_VSUM, lo);
      rd(`CDC_IDX_VSUM, hi);
      chk({hi[15:0], lo[15:0]}, {16'h0, k} * per(sel));
      rchk(`CDC_IDX_VCTRL, {29'h0, sel, 1'b0});
      $display("variance test %0d done", i);
    end
    report_and_stop;
  end
  initial begin
    repeat (30000) @(posedge MCLK);
    err_count++;
    $display("Error at %0t: watchdog expired", $time);
    report_and_stop;
  end
endmodule
